// ===== sixteen_bit_spi_target.v
/*
 * sixteen-bit serial target port with a 16-word command fifo toward the device core.
 * assumes a controller-driven serial clock far slower than mclk (2 sync stages + edge detect).
 */
`timescale 1ns/10ps
`include "spi_target_consts.vh"

// ==========================================================
// command fifo
module cmd_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             mclk,
   input  wire             nrst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   wire            empty;
   wire            full;
   wire            do_wr;
   wire            do_rd;

   assign empty     = (wr_ptr == rd_ptr);
   assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign do_wr     = in_valid & ~full;
   assign do_rd     = out_ready & ~empty;

   always @(posedge mclk) begin
      if (do_wr)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end

   always @* begin
      out_data = mem[rd_ptr[AW-1:0]];
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr)
            wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
         if (do_rd)
            rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
   end
endmodule

// ==========================================================
// serial target
// How it works
// - each frame moves one 16-bit word from controller into the receive register
// - response word is shifted out on the output line during the same frame
// - frames start on select low; clock and input ignored while select high
// - received word is decoded only when select rises
// - output driver released to high impedance when select rises
// - input line sampled and shifted in on each falling serial clock edge
// - next response bit placed on output after each rising serial clock edge
// - clock count other than 0 or 16 discards word and records frame error
// - bits 6..0 address, bit 7 access kind, bits 15..8 data byte
// - latched frame error drives output high before first rising edge of next frame
// - no received word is interpreted while in the recovery restart state
module sixteen_bit_spi_target (
   input  wire        mclk,
   input  wire        nrst,
   input  wire        sclk,
   input  wire        csn,
   input  wire        sdi,
   output reg         sdo_out,
   output reg         sdo_oe,
   input  wire        recovery_restart_state,
   input  wire [15:0] resp_word,
   output wire [6:0]  cmd_addr,
   output wire        cmd_rw,
   output wire [7:0]  cmd_data,
   output wire        cmd_valid,
   input  wire        cmd_ready,
   output wire        cmd_in_ready,
   output reg         frame_error
);
   reg  [1:0]             sclk_s;
   reg  [1:0]             csn_s;
   reg  [1:0]             sdi_s;
   reg                    sclk_d;
   reg                    csn_d;
   reg  [`WORD_BITS-1:0]  rx_sr;
   reg  [`WORD_BITS-1:0]  tx_sr;
   reg  [`CNT_BITS-1:0]   bit_cnt;
   reg                    err_pending;
   reg                    cmd_push;
   reg  [`WORD_BITS-1:0]  cmd_word;
   wire                   sclk_rise;
   wire                   sclk_fall;
   wire                   cs_fall;
   wire                   cs_rise;
   wire                   selected;
   wire                   cnt_bad;
   wire [`WORD_BITS-1:0]  fifo_out;

   // ==========================================================
   // synchronisers and edges
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sclk_s <= 2'h0;
         csn_s  <= 2'h3;
         sdi_s  <= 2'h0;
         sclk_d <= 1'b0;
         csn_d  <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[0], sclk};
         csn_s  <= {csn_s[0], csn};
         sdi_s  <= {sdi_s[0], sdi};
         sclk_d <= sclk_s[1];
         csn_d  <= csn_s[1];
      end
   end

   assign selected  = ~csn_s[1] & ~csn_d;
   assign sclk_rise = selected & sclk_s[1] & ~sclk_d;
   assign sclk_fall = selected & ~sclk_s[1] & sclk_d;
   assign cs_fall   = ~csn_s[1] & csn_d;
   assign cs_rise   = csn_s[1] & ~csn_d;
   assign cnt_bad   = (bit_cnt != `CNT_ZERO) && (bit_cnt != `CNT_FULL);

   // ==========================================================
   // shift, count, frame end
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx_sr       <= {`WORD_BITS{1'b0}};
         tx_sr       <= {`WORD_BITS{1'b0}};
         bit_cnt     <= `CNT_ZERO;
         sdo_out     <= 1'b0;
         sdo_oe      <= 1'b0;
         err_pending <= 1'b0;
         frame_error <= 1'b0;
         cmd_push    <= 1'b0;
         cmd_word    <= {`WORD_BITS{1'b0}};
      end else begin
         cmd_push    <= 1'b0;
         frame_error <= 1'b0;
         if (cs_fall) begin
            bit_cnt <= `CNT_ZERO;
            sdo_oe  <= 1'b1;
            if (err_pending) begin
               sdo_out <= 1'b1;
               tx_sr   <= {resp_word[`WORD_BITS-2:0], 1'b1};
            end else begin
               sdo_out <= resp_word[`WORD_BITS-1];
               tx_sr   <= {resp_word[`WORD_BITS-2:0], 1'b0};
            end
            err_pending <= 1'b0;
         end else if (cs_rise) begin
            sdo_oe <= 1'b0;
            if (cnt_bad) begin
               err_pending <= 1'b1;
               frame_error <= 1'b1;
            end else if (bit_cnt == `CNT_FULL && !recovery_restart_state) begin
               cmd_push <= 1'b1;
               cmd_word <= rx_sr;
            end
         end else begin
            if (sclk_fall) begin
               rx_sr <= {rx_sr[`WORD_BITS-2:0], sdi_s[1]};
               if (bit_cnt != `CNT_SAT)
                  bit_cnt <= bit_cnt + 5'h01;
            end
            if (sclk_rise) begin
               sdo_out <= tx_sr[`WORD_BITS-1];
               tx_sr   <= {tx_sr[`WORD_BITS-2:0], 1'b0};
            end
         end
      end
   end

   // ==========================================================
   // command queue and fields
   cmd_fifo #(
      .WIDTH (`WORD_BITS),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_data   (cmd_word),
      .in_valid  (cmd_push),
      .in_ready  (cmd_in_ready),
      .out_data  (fifo_out),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready)
   );

   assign cmd_addr = fifo_out[`ADDR_MSB:`ADDR_LSB];
   assign cmd_rw   = fifo_out[`RW_BIT];
   assign cmd_data = fifo_out[`DATA_MSB:`DATA_LSB];
endmodule

// ===== spi_ctrl_model.sv
/* controller model: select, serial clock, input line.
   assumes mclk and the resolved output line from the bench. */
`timescale 1ns/10ps
// ==========
// controller
module spi_ctrl_model (
   input  wire logic mclk,
   input  wire logic sdo,
   output logic      sclk = 1'b0,
   output logic      csn = 1'b1,
   output logic      sdi = 1'b0
);
   task automatic xfer(input logic [15:0] w, input int n, input logic sel,
                       output logic [15:0] r);
      r = 16'h0000;
      csn = ~sel;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < n; i++) begin
         r = {r[14:0], sdo};
         sdi = w[15 - i];
         sclk = 1'b1;
         repeat (4) @(negedge mclk);
         sclk = 1'b0;
         repeat (4) @(negedge mclk);
      end
      csn = 1'b1;
      sdi = ~sdi;
      repeat (10) @(negedge mclk);
   endtask
endmodule

// ===== spi_target_consts.vh
/*
 * constants of the sixteen-bit serial target port: frame size, field positions, fifo shape.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SPI_TARGET_CONSTS_VH
`define SPI_TARGET_CONSTS_VH

// ==========================================================
// frame
`define WORD_BITS      16
`define CNT_BITS       5
`define CNT_FULL       5'h10
`define CNT_ZERO       5'h00
`define CNT_SAT        5'h1F
// ==========================================================
// word layout
`define ADDR_LSB       0
`define ADDR_MSB       6
`define RW_BIT         7
`define DATA_LSB       8
`define DATA_MSB       15
// ==========================================================
// fifo
`define FIFO_DEPTH     16
`define FIFO_AW        4

`endif

// ===== sst_assertions.sv
/* assertions on the serial target port.
   bound onto the top module from the bench. */
`timescale 1ns/10ps
// ==========
// checker
module sst_checker (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic csn,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic recovery_restart_state,
   input wire logic cmd_valid,
   input wire logic frame_error
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_on; $fell(csn) |-> ##[2:4] sdo_oe; endproperty
   a_on: assert property (p_on) else $error("oe late");
   property p_off; $rose(csn) |-> ##[2:4] !sdo_oe; endproperty
   a_off: assert property (p_off) else $error("oe stuck");
   property p_idle; csn [*5] |-> !sdo_oe; endproperty
   a_idle: assert property (p_idle) else $error("idle drive");
   property p_bit; sdo_oe && $past(sdo_oe) && $changed(sdo_out) |-> $past(sclk, 3); endproperty
   a_bit: assert property (p_bit) else $error("sdo moved");
   property p_mid; !csn [*6] |-> !$rose(cmd_valid); endproperty
   a_mid: assert property (p_mid) else $error("early push");
   property p_drop; frame_error |-> (!$rose(cmd_valid)) [*4]; endproperty
   a_drop: assert property (p_drop) else $error("bad push");
   property p_pulse; frame_error |=> !frame_error; endproperty
   a_pulse: assert property (p_pulse) else $error("err long");
   property p_rst; recovery_restart_state && $rose(csn) |-> (!$rose(cmd_valid)) [*6]; endproperty
   a_rst: assert property (p_rst) else $error("restart push");
   cover property ($rose(cmd_valid));
   cover property (frame_error);
   cover property (recovery_restart_state && $rose(csn));
endmodule

// ===== test_sixteen_bit_spi_target.sv
/* bench for the serial target port.
   assumes checker and controller model compiled first. */
`timescale 1ns/10ps
// ==========
// bench
module test_sixteen_bit_spi_target;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        recovery_restart_state = 1'b0;
   logic [15:0] resp_word = 16'h0000;
   logic        cmd_ready = 1'b0;
   logic [15:0] rx;
   int          num_errors = 0;
   int          check_count = 0;
   logic [15:0] err_pulses = 16'h0000;
   wire         sclk, csn, sdi, sdo_out, sdo_oe, cmd_rw, cmd_valid, cmd_in_ready, frame_error;
   wire  [6:0]  cmd_addr;
   wire  [7:0]  cmd_data;
   wire         sdo = sdo_oe ? sdo_out : 1'b1;
   always #20 mclk = ~mclk;
   // count one-cycle error pulses where they stand settled
   always @(negedge mclk) if (frame_error === 1'b1) err_pulses <= err_pulses + 16'h0001;
   sixteen_bit_spi_target dut (.mclk, .nrst, .sclk, .csn, .sdi, .sdo_out, .sdo_oe,
      .recovery_restart_state, .resp_word, .cmd_addr, .cmd_rw, .cmd_data, .cmd_valid,
      .cmd_ready, .cmd_in_ready, .frame_error);
   spi_ctrl_model ctl (.mclk, .sdo, .sclk, .csn, .sdi);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task drain(input logic [15:0] exp);
      logic [15:0] n;
      n = 16'h0000;
      cmd_ready = 1'b1;
      repeat (40) begin
         if (cmd_valid === 1'b1) n++;
         @(negedge mclk);
      end
      cmd_ready = 1'b0;
      chk(n, exp);
   endtask
   task t_basic;
      resp_word = 16'hA55A;
      ctl.xfer(16'h3C81, 16, 1'b1, rx);
      chk(rx, 16'hA55A);
      chk({cmd_data, cmd_rw, cmd_addr}, 16'h3C81);
      drain(16'h0001);
   endtask
   task t_err;
      resp_word = 16'h1234;
      ctl.xfer(16'h0000, 0, 1'b1, rx);
      ctl.xfer(16'h5502, 5, 1'b1, rx);
      chk(err_pulses, 16'h0001);
      ctl.xfer(16'h1102, 16, 1'b1, rx);
      chk(rx, 16'h9234);
      ctl.xfer(16'h1102, 16, 1'b1, rx);
      chk(rx, 16'h1234);
      drain(16'h0002);
   endtask
   task t_ignore;
      ctl.xfer(16'h7701, 16, 1'b0, rx);
      chk(rx, 16'hFFFF);
      recovery_restart_state = 1'b1;
      ctl.xfer(16'h7701, 16, 1'b1, rx);
      recovery_restart_state = 1'b0;
      chk(cmd_valid, 1'b0);
   endtask
   task t_fill;
      for (int i = 0; i < 17; i++) ctl.xfer(16'h0100 + i[15:0], 16, 1'b1, rx);
      chk(cmd_in_ready, 1'b0);
      chk({cmd_data, cmd_rw, cmd_addr}, 16'h0100);
      drain(16'h0010);
   endtask
   task t_reset;
      resp_word = 16'h1234;
      ctl.xfer(16'h4404, 16, 1'b1, rx);
      ctl.xfer(16'h0000, 3, 1'b1, rx);
      chk(err_pulses, 16'h0002);
      nrst = 1'b0;
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      chk({sdo_oe, cmd_valid, frame_error, cmd_in_ready}, 4'h1);
      ctl.xfer(16'h4404, 16, 1'b1, rx);
      chk(rx, 16'h1234);
      chk({cmd_data, cmd_rw, cmd_addr}, 16'h4404);
      drain(16'h0001);
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      chk({sdo_oe, cmd_valid, frame_error}, 3'h0);
      t_basic;
      t_err;
      t_ignore;
      t_fill;
      t_reset;
      final_report;
   end
   initial begin
      repeat (9000) @(posedge mclk);
      num_errors++;
      final_report;
   end
endmodule
bind sixteen_bit_spi_target sst_checker chk_i (.mclk, .nrst, .sclk, .csn, .sdo_out, .sdo_oe,
   .recovery_restart_state, .cmd_valid, .frame_error);
